// File: inc/mci_pkg.sv
/*
 * Shared constants, types and helpers of the motion command interpreter.
 * Assumes a single core clock domain; images are ten 16-bit words each way.
 */
package mci_pkg;
    localparam int          MCI_WORDS      = 10;
    localparam logic [3:0]  MCI_IDX_COMMIT = 4'ha;
    localparam logic [3:0]  MCI_IDX_LAST   = 4'h9;
    // Configuration word 0 fields (mode and format control).
    localparam int          MCI_MODE_BIT   = 15;
    localparam int          MCI_FLAG_BIT   = 13;
    localparam int          MCI_READ_BIT   = 11;
    localparam int          MCI_SAVE_BIT   = 10;
    localparam int          MCI_INFMT_BIT  = 9;
    localparam int          MCI_OUTFMT_BIT = 8;
    localparam int          MCI_ENDIAN_BIT = 7;
    localparam int          MCI_LVLB_BIT   = 1;
    localparam int          MCI_LVLA_BIT   = 0;
    localparam logic [15:0] MCI_CW0_RSVD   = 16'h707c;
    // Configuration word 1 fields (input functions, stall and encoder use).
    localparam int          MCI_FUNCA_LSB  = 0;
    localparam int          MCI_FUNCB_LSB  = 3;
    localparam int          MCI_STALL_BIT  = 13;
    localparam int          MCI_ENC_BIT    = 14;
    localparam logic [15:0] MCI_CW1_RSVD   = 16'h9fc0;
    localparam logic [2:0]  MCI_FUNC_GPI   = 3'h0;
    localparam logic [2:0]  MCI_FUNC_BAD   = 3'h7;
    // Parameter limits.
    localparam logic [15:0] MCI_SPEED_HI_MAX = 16'h0001;
    localparam logic [15:0] MCI_SPEED_LO_MAX = 16'h03e7;
    localparam logic [15:0] MCI_STEPS_MIN    = 16'h00c8;
    localparam logic [15:0] MCI_STEPS_MAX    = 16'h8000;
    localparam logic [15:0] MCI_IDLE_MAX     = 16'h0064;
    localparam logic [15:0] MCI_CURRENT_MAX  = 16'h0034;
    localparam logic signed [31:0] MCI_SCALE = 32'sh000003e8;
    // Save status codes in response word 9.
    localparam logic [15:0] MCI_SAVE_OK    = 16'haaaa;
    localparam logic [15:0] MCI_SAVE_FAIL  = 16'heeee;
    localparam logic [15:0] MCI_ZERO       = 16'h0000;

    typedef enum logic {MCI_CMD, MCI_CFG} mci_mode_t;

    typedef struct packed {
        logic [15:0] cw0;
        logic [15:0] cw1;
        logic [15:0] speedHi;
        logic [15:0] speedLo;
        logic [15:0] steps;
        logic [15:0] encRes;
        logic [15:0] idle;
        logic [15:0] current;
    } mci_cfg_t;

    typedef logic [MCI_WORDS-1:0][15:0] mci_image_t;

    // Two words to a 32-bit value under the selected format and order.
    function automatic logic signed [31:0] mci_decode(input logic [15:0] first,
            input logic [15:0] second, input logic fmt32, input logic bigEnd);
        logic signed [31:0] prod;
        prod = $signed({{16{first[15]}}, first}) * MCI_SCALE;
        if (!fmt32)
            return prod + $signed({{16{second[15]}}, second});
        return bigEnd ? {first, second} : {second, first};
    endfunction

    // A 32-bit value to two words; first word in [31:16], second in [15:0].
    function automatic logic [31:0] mci_encode(input logic signed [31:0] val,
            input logic fmt32, input logic bigEnd);
        logic signed [31:0] quo;
        logic signed [31:0] rem;
        quo = val / MCI_SCALE;
        rem = val % MCI_SCALE;
        if (!fmt32)
            return {quo[15:0], rem[15:0]};
        return bigEnd ? val : {val[15:0], val[31:16]};
    endfunction
endpackage

// File: rtl/mci_core.sv
/*
 * Command and configuration interpreter of an integrated stepper indexer.
 * The host writes ten output words, then the commit index, once per network
 * cycle, and reads the ten response words. Positions, status and flash
 * results come from logic on the same clock; the two sensor pins do not.
 */
// Strobed register access and the address map were decided locally.
// What this block does
// - Each input has a level bit: 0 active without current, 1 active with current.
// - A new idle current applies only when the first following move finishes.
// - Config mode echoes words 0-8, word 5 zero, word 9 zero or save status.
// - Invalid configuration selects command mode and sets the error flag in word 0.
// - Word 0 bit 13 means stall enable in config mode, config error in command.
// - Reject reserved bits set, parameters out of range, speed lower word above 999.
// - Reject both inputs with one function unless both are general purpose.
// - Reject stall detection without the built-in encoder in use.
// - Reject input function code 111 on either input.
// - Both images are ten 16-bit words.
// - After reset all 32-bit quantities use multi-word encoding.
// - Multi-word: first word value/1000, second remainder, both signed.
// - Positions beyond the multi-word range give undefined words.
// - Separate format bits for commanded parameters and reported positions.
// - In 32-bit mode a word-order bit puts low or high half first.
// - A command bit acts only on a 0 to 1 change between writes.
// - A bit held across the switch from config to command mode does not fire.
// - In command mode words 0 and 1 are commands, 2-7 parameters.
// - Save rising edge with valid data writes flash; word 9 shows aaaa or eeee.
// - Command word 0 bit 15 selects configuration (1) or command (0) mode.
// - Read bit on config entry reports stored setup and blocks writes while set.
`timescale 1ns/1ps
module mci_core
    import mci_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port.
    input  wire logic [3:0]           addr,
    input  wire logic [15:0]          wrData,
    input  wire logic                 wrStb,
    input  wire logic                 rdStb,
    output logic [15:0]               rdData,
    // Sensor pins.
    input  wire logic [1:0]           sensorPin,
    output logic [1:0]                inputActive,
    // Motion core side.
    input  wire logic signed [31:0]   motorPos,
    input  wire logic signed [31:0]   encoderPos,
    input  wire logic signed [31:0]   capturedPos,
    input  wire logic [15:0]          statusWord0,
    input  wire logic [15:0]          statusWord1,
    input  wire logic                 moveDone,
    output logic [15:0]               cmdEdge0,
    output logic [15:0]               cmdEdge1,
    output logic [15:0]               cmdLevel1,
    output logic [2:0][31:0]          cmdParam,
    output mci_pkg::mci_cfg_t         activeCfg,
    output logic [15:0]               idleApplied,
    // Flash store.
    input  wire logic                 flashDone,
    input  wire logic                 flashFail,
    output logic                      flashReq
);
    import mci_pkg::*;

    mci_image_t      outImg_reg;
    mci_image_t      resp;
    mci_cfg_t        cfg_reg;
    mci_cfg_t        newCfg;
    mci_mode_t       mode_reg;
    logic [15:0]     prevCmd0_reg;
    logic [15:0]     prevCmd1_reg;
    logic            cfgErr_reg;
    logic            readLock_reg;
    logic            idlePend_reg;
    logic [15:0]     saveStatus_reg;
    logic [1:0]      pinMeta_reg;
    logic [1:0]      pinSync_reg;
    logic            commit;
    logic            wantCfg;
    logic            lockHold;
    logic            cfgValid;
    logic [2:0]      funcA;
    logic [2:0]      funcB;
    logic [31:0]     encMotor;
    logic [31:0]     encEnc;
    logic [31:0]     encCap;

    assign commit = wrStb && addr == MCI_IDX_COMMIT;

    // Host output image, one word per index.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outImg_reg <= '0;
        end else if (wrStb && addr <= MCI_IDX_LAST) begin
            outImg_reg[addr] <= wrData;
        end
    end

    // Candidate configuration taken from the output image.
    always_comb begin
        newCfg = '{cw0: outImg_reg[0], cw1: outImg_reg[1], speedHi: outImg_reg[2],
                   speedLo: outImg_reg[3], steps: outImg_reg[4], encRes: outImg_reg[6],
                   idle: outImg_reg[7], current: outImg_reg[8]};
        funcA = newCfg.cw1[MCI_FUNCA_LSB +: 3];
        funcB = newCfg.cw1[MCI_FUNCB_LSB +: 3];
    end

    // Validity of the candidate configuration.
    always_comb begin
        cfgValid = 1'b1;
        if ((newCfg.cw0 & MCI_CW0_RSVD) != MCI_ZERO || (newCfg.cw1 & MCI_CW1_RSVD) != MCI_ZERO
                || outImg_reg[5] != MCI_ZERO) begin
            cfgValid = 1'b0;
        end
        if (newCfg.speedHi > MCI_SPEED_HI_MAX || newCfg.speedLo > MCI_SPEED_LO_MAX
                || newCfg.steps < MCI_STEPS_MIN || newCfg.steps > MCI_STEPS_MAX
                || newCfg.idle > MCI_IDLE_MAX || newCfg.current > MCI_CURRENT_MAX) begin
            cfgValid = 1'b0;
        end
        if (funcA == funcB && funcA != MCI_FUNC_GPI) begin
            cfgValid = 1'b0;
        end
        if (newCfg.cw1[MCI_STALL_BIT] && !newCfg.cw1[MCI_ENC_BIT]) begin
            cfgValid = 1'b0;
        end
        if (funcA == MCI_FUNC_BAD || funcB == MCI_FUNC_BAD) begin
            cfgValid = 1'b0;
        end
    end

    assign wantCfg  = outImg_reg[0][MCI_MODE_BIT];
    // Entering with the read bit, or keeping it set after such an entry, blocks writes.
    assign lockHold = wantCfg && outImg_reg[0][MCI_READ_BIT]
                      && (mode_reg == MCI_CMD || readLock_reg);

    // Mode, error flag, read lock and working configuration.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg     <= MCI_CMD;
            cfgErr_reg   <= 1'b0;
            readLock_reg <= 1'b0;
            cfg_reg      <= '0;
        end else if (commit) begin
            if (!wantCfg) begin
                mode_reg     <= MCI_CMD;
                readLock_reg <= 1'b0;
            end else if (lockHold) begin
                mode_reg     <= MCI_CFG;
                readLock_reg <= 1'b1;
            end else if (cfgValid) begin
                mode_reg     <= MCI_CFG;
                readLock_reg <= 1'b0;
                cfgErr_reg   <= 1'b0;
                cfg_reg      <= newCfg;
            end else begin
                mode_reg     <= MCI_CMD;
                readLock_reg <= 1'b0;
                cfgErr_reg   <= 1'b1;
            end
        end
    end

    // Idle current waits for the end of the first move after reconfiguration.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idlePend_reg <= 1'b0;
            idleApplied  <= MCI_ZERO;
        end else if (commit && wantCfg && !lockHold && cfgValid) begin
            idlePend_reg <= 1'b1;
        end else if (moveDone && idlePend_reg) begin
            idlePend_reg <= 1'b0;
            idleApplied  <= cfg_reg.idle;
        end
    end

    // Flash save request and its reported outcome.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flashReq       <= 1'b0;
            saveStatus_reg <= MCI_ZERO;
        end else begin
            flashReq <= commit && wantCfg && !lockHold && cfgValid
                        && outImg_reg[0][MCI_SAVE_BIT] && !prevCmd0_reg[MCI_SAVE_BIT];
            if (flashDone) begin
                saveStatus_reg <= MCI_SAVE_OK;
            end else if (flashFail) begin
                saveStatus_reg <= MCI_SAVE_FAIL;
            end else if (commit && wantCfg && mode_reg == MCI_CMD) begin
                saveStatus_reg <= MCI_ZERO;
            end
        end
    end

    // Command edges: previous words are kept across both modes, so a bit held
    // over the switch into command mode never looks like a fresh edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevCmd0_reg <= MCI_ZERO;
            prevCmd1_reg <= MCI_ZERO;
            cmdEdge0     <= MCI_ZERO;
            cmdEdge1     <= MCI_ZERO;
        end else begin
            cmdEdge0 <= MCI_ZERO;
            cmdEdge1 <= MCI_ZERO;
            if (commit) begin
                prevCmd0_reg <= outImg_reg[0];
                prevCmd1_reg <= outImg_reg[1];
                if (!wantCfg) begin
                    cmdEdge0 <= outImg_reg[0] & ~prevCmd0_reg;
                    cmdEdge1 <= outImg_reg[1] & ~prevCmd1_reg;
                end
            end
        end
    end

    // Command level word and decoded parameter pairs (words 2-3, 4-5, 6-7).
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdLevel1 <= MCI_ZERO;
            cmdParam  <= '0;
        end else if (commit && !wantCfg) begin
            cmdLevel1 <= outImg_reg[1];
            for (int i = 0; i < 3; i++) begin
                cmdParam[i] <= mci_decode(outImg_reg[2 + 2 * i], outImg_reg[3 + 2 * i],
                                          cfg_reg.cw0[MCI_OUTFMT_BIT],
                                          cfg_reg.cw0[MCI_ENDIAN_BIT]);
            end
        end
    end

    // Sensor pins: two flops, then the level select.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_reg <= 2'h0;
            pinSync_reg <= 2'h0;
            inputActive <= 2'h0;
        end else begin
            pinMeta_reg    <= sensorPin;
            pinSync_reg    <= pinMeta_reg;
            inputActive[0] <= cfg_reg.cw0[MCI_LVLA_BIT] ? pinSync_reg[0] : !pinSync_reg[0];
            inputActive[1] <= cfg_reg.cw0[MCI_LVLB_BIT] ? pinSync_reg[1] : !pinSync_reg[1];
        end
    end

    assign activeCfg = cfg_reg;

    // Reported positions; beyond the multi-word range the words are not meaningful.
    assign encMotor = mci_encode(motorPos, cfg_reg.cw0[MCI_INFMT_BIT],
                                 cfg_reg.cw0[MCI_ENDIAN_BIT]);
    assign encEnc   = mci_encode(encoderPos, cfg_reg.cw0[MCI_INFMT_BIT],
                                 cfg_reg.cw0[MCI_ENDIAN_BIT]);
    assign encCap   = mci_encode(capturedPos, cfg_reg.cw0[MCI_INFMT_BIT],
                                 cfg_reg.cw0[MCI_ENDIAN_BIT]);

    // Response image for the current mode.
    always_comb begin
        resp = '0;
        if (mode_reg == MCI_CFG) begin
            resp[0] = cfg_reg.cw0;
            resp[0][MCI_FLAG_BIT] = cfg_reg.cw1[MCI_STALL_BIT];
            resp[1] = cfg_reg.cw1;
            resp[2] = cfg_reg.speedHi;
            resp[3] = cfg_reg.speedLo;
            resp[4] = cfg_reg.steps;
            resp[6] = cfg_reg.encRes;
            resp[7] = cfg_reg.idle;
            resp[8] = cfg_reg.current;
            resp[9] = saveStatus_reg;
        end else begin
            resp[0] = statusWord0;
            resp[0][MCI_MODE_BIT] = 1'b0;
            resp[0][MCI_FLAG_BIT] = cfgErr_reg;
            resp[1] = statusWord1;
            {resp[2], resp[3]} = encMotor;
            {resp[4], resp[5]} = encEnc;
            {resp[6], resp[7]} = encCap;
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= MCI_ZERO;
        end else if (rdStb && addr <= MCI_IDX_LAST) begin
            rdData <= resp[addr];
        end else begin
            rdData <= MCI_ZERO;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    level_select_a: assert property ($past(pinSync_reg[0]) != 1'b0 && cfg_reg.cw0[MCI_LVLA_BIT]
            && $stable(cfg_reg) |-> inputActive[0]) else $error("input a level wrong");
    idle_hold_a: assert property (!$past(moveDone) |-> $stable(idleApplied))
        else $error("idle current changed without a finished move");
    cfg_echo_a: assert property (mode_reg == MCI_CFG |-> resp[5] == MCI_ZERO
            && resp[3] == cfg_reg.speedLo) else $error("config echo wrong");
    bad_cfg_a: assert property (commit && wantCfg && !lockHold && !cfgValid
            |=> mode_reg == MCI_CMD && cfgErr_reg && $stable(cfg_reg))
        else $error("invalid config accepted");
    flag_mean_a: assert property (mode_reg == MCI_CMD |-> resp[0][MCI_FLAG_BIT] == cfgErr_reg
            && !resp[0][MCI_MODE_BIT]) else $error("flag meaning wrong");
    speed_limit_a: assert property (commit && outImg_reg[3] > MCI_SPEED_LO_MAX
            |=> $stable(cfg_reg)) else $error("speed lower word over limit taken");
    dup_func_a: assert property (commit && funcA == funcB && funcA != MCI_FUNC_GPI
            |=> $stable(cfg_reg)) else $error("duplicate input function taken");
    edge_only_a: assert property (commit && !wantCfg
            |=> cmdEdge0 == ($past(outImg_reg[0]) & ~$past(prevCmd0_reg)) ##1 cmdEdge0 == 16'h0000
            || $past(commit)) else $error("command edge wrong");
    save_req_a: assert property (flashReq |-> $past(commit) && $past(cfgValid)
            && $past(wantCfg)) else $error("save without valid data");
    read_lock_a: assert property (commit && lockHold |=> $stable(cfg_reg)
            && mode_reg == MCI_CFG) else $error("write taken under read lock");

    cfg_accept_c: cover property (commit && wantCfg && cfgValid ##1 mode_reg == MCI_CFG);
    cmd_fire_c: cover property (commit && !wantCfg ##1 cmdEdge0 != 16'h0000);
    save_ok_c: cover property (flashReq ##[1:20] saveStatus_reg == MCI_SAVE_OK);
    cfg_err_c: cover property (commit && wantCfg && !cfgValid ##1 cfgErr_reg);
endmodule

// File: tb/mci_far_model.sv
/*
 * Far-side model of the interpreter: a motion core that finishes the latest
 * started move after a fixed run time, and a flash store that answers
 * the latest write request after a fixed delay, failing on command.
 * Assumes the interpreter's clock, reset and one-cycle pulse outputs.
 */
`timescale 1ns/1ps
module mci_far_model #(
    parameter int MOVE_LEN  = 6,
    parameter int FLASH_LEN = 9
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Motion core side.
    input  wire logic [15:0] cmdEdge0,
    output logic             moveDone,
    // Flash store.
    input  wire logic        flashReq,
    input  wire logic        failNext,
    output logic             flashDone,
    output logic             flashFail
);
    int moveCnt;
    int flashCnt;

    // Absolute and relative move starts reload the count; one done pulse follows the last start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            moveCnt  <= 0;
            moveDone <= 1'b0;
        end else begin
            moveDone <= (moveCnt == 1);
            if (|cmdEdge0[1:0])
                moveCnt <= MOVE_LEN;
            else if (moveCnt != 0)
                moveCnt <= moveCnt - 1;
        end
    end

    // The store reports one result for the latest of any overlapping requests; failNext picks which one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flashCnt  <= 0;
            flashDone <= 1'b0;
            flashFail <= 1'b0;
        end else begin
            flashDone <= (flashCnt == 1) && !failNext;
            flashFail <= (flashCnt == 1) && failNext;
            if (flashReq)
                flashCnt <= FLASH_LEN;
            else if (flashCnt != 0)
                flashCnt <= flashCnt - 1;
        end
    end
endmodule

// File: tb/mci_core_tb_top.sv
/*
 * Self-checking bench of the command interpreter: register port driver,
 * expectation queues checked by a watcher process, and the scenarios.
 * Assumes mci_far_model on the motion core and flash store side.
 */
`timescale 1ns/1ps
module mci_core_tb_top;
    import mci_pkg::*;
    logic clk, rst, wrStb, rdStb, moveDone, flashDone, flashFail, flashReq, failNext, rdPend;
    logic [3:0]         addr;
    logic [15:0]        wrData, rdData, statusWord0, statusWord1, cmdEdge0, cmdEdge1;
    logic [15:0]        cmdLevel1, idleApplied;
    logic [1:0]         sensorPin, inputActive;
    logic signed [31:0] motorPos, encoderPos, capturedPos, p;
    logic [31:0]        e, seed;
    logic [2:0][31:0]   cmdParam;
    mci_cfg_t           activeCfg;
    int                 errTotal, comparisons;
    logic [15:0]        rdQ[$], edgeQ[$], good[9], w[9];
    logic [2:0]         fmts[6] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    int                 badIdx[9] = '{1, 3, 1, 1, 1, 7, 4, 5, 2};
    logic [15:0]        badVal[9] = '{16'h6041, 16'h03e8, 16'h4009, 16'h2001, 16'h4007,
                                      16'h0065, 16'h00c7, 16'h0001, 16'h0002};

    mci_core dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .sensorPin(sensorPin), .inputActive(inputActive),
        .motorPos(motorPos), .encoderPos(encoderPos), .capturedPos(capturedPos),
        .statusWord0(statusWord0), .statusWord1(statusWord1), .moveDone(moveDone),
        .cmdEdge0(cmdEdge0), .cmdEdge1(cmdEdge1), .cmdLevel1(cmdLevel1), .cmdParam(cmdParam),
        .activeCfg(activeCfg), .idleApplied(idleApplied), .flashDone(flashDone),
        .flashFail(flashFail), .flashReq(flashReq));
    mci_far_model #(.MOVE_LEN(6), .FLASH_LEN(9)) far (.clk(clk), .rst(rst),
        .cmdEdge0(cmdEdge0), .moveDone(moveDone), .flashReq(flashReq), .failNext(failNext),
        .flashDone(flashDone), .flashFail(flashFail));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected pair of words, first word in the upper half.
    function automatic logic [31:0] enc2(input logic signed [31:0] v, input logic f32,
            input logic big);
        logic signed [31:0] q;
        logic signed [31:0] r;
        q = v / 32'sd1000;
        r = v % 32'sd1000;
        if (!f32)
            return {q[15:0], r[15:0]};
        return big ? v : {v[15:0], v[31:16]};
    endfunction
    function automatic logic [111:0] pk(input logic [15:0] x[9]);
        return {x[1], x[2], x[3], x[4], x[6], x[7], x[8]};
    endfunction

    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkWide(input logic [111:0] got, input logic [111:0] exp);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [3:0] a, input logic [15:0] d, input logic ws, input logic rs);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= ws;
        rdStb  <= rs;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        put(a, d, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        rdQ.push_back(exp);
        put(a, 16'h0000, 1'b0, 1'b1);
    endtask
    task automatic idle();
        put(4'h0, 16'h0000, 1'b0, 1'b0);
    endtask
    // Writes configuration words 0-8, commits, and lets the commit land.
    task automatic cfgw(input logic [15:0] x[9]);
        for (int i = 0; i < 9; i++)
            wr(4'(i), x[i]);
        wr(4'ha, 16'h0000);
        idle();
    endtask
    task automatic readCmd(input logic f32, input logic big);
        logic [31:0] v;
        rd(4'h0, statusWord0 & 16'h5fff);
        rd(4'h1, statusWord1);
        for (int i = 0; i < 3; i++) begin
            v = enc2(i == 0 ? motorPos : i == 1 ? encoderPos : capturedPos, f32, big);
            rd(4'(2 + 2 * i), v[31:16]);
            rd(4'(3 + 2 * i), v[15:0]);
        end
        idle();
    endtask
    task automatic waitFlash();
        int n;
        n = 0;
        while (!(flashDone || flashFail) && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) begin
            errTotal++;
            stopTest();
        end
    endtask
    task automatic sense(input logic [1:0] pins, input logic [15:0] exp);
        @(posedge clk);
        sensorPin <= pins;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chkWord({14'h0, inputActive}, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        stopTest();
    end
    always @(posedge clk) rdPend <= rdStb;
    // Read data stand only in the cycle after the strobe; edges for one cycle.
    always @(negedge clk) begin
        if (rdPend)
            chkWord(rdData, rdQ.size() != 0 ? rdQ.pop_front() : 16'hxxxx);
        if (cmdEdge0[6:0] != 7'h0)
            chkWord(cmdEdge0 & 16'h007f, edgeQ.size() != 0 ? edgeQ.pop_front() : 16'h0000);
    end

    initial begin
        seed = 32'h9771;
        errTotal = 0;
        comparisons = 0;
        rst = 1'b1;
        {addr, wrData, wrStb, rdStb, rdPend, sensorPin, failNext} = '0;
        {statusWord0, statusWord1, capturedPos} = '0;
        motorPos = 32'sd12;
        encoderPos = -32'sd7654321;
        good = '{16'h8000, 16'h6001, 16'h0001, 16'h03e7, 16'h00c8, 16'h0000, 16'h0400,
                 16'h0064, 16'h0034};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        capturedPos <= $signed(rnd()) % 32'sd32767999;
        statusWord0 <= 16'(rnd());
        statusWord1 <= 16'(rnd());
        edgeQ.push_back(16'h0002);
        wr(4'h0, 16'h0002);
        wr(4'ha, 16'h0000);
        readCmd(1'b0, 1'b0);
        $display("test 1 done");
        cfgw(good);
        rd(4'h0, 16'ha000);
        for (int i = 1; i < 9; i++)
            rd(4'(i), i == 5 ? 16'h0000 : good[i]);
        rd(4'h9, 16'h0000);
        idle();
        @(negedge clk);
        chkWide(activeCfg[111:0], pk(good));
        chkWord(idleApplied, 16'h0000);
        $display("test 2 done");
        w = good;
        w[0] = 16'h8001;
        cfgw(w);
        wr(4'h0, 16'h0001);
        wr(4'ha, 16'h0000);
        wr(4'h0, 16'h0000);
        wr(4'ha, 16'h0000);
        wr(4'h0, 16'h0001);
        edgeQ.push_back(16'h0001);
        wr(4'ha, 16'h0000);
        wr(4'ha, 16'h0000);
        idle();
        for (int n = 0; n < 30 && idleApplied !== 16'h0064; n++)
            @(negedge clk);
        chkWord(idleApplied, 16'h0064);
        $display("test 3 done");
        foreach (badIdx[k]) begin
            w = good;
            w[badIdx[k]] = badVal[k];
            cfgw(w);
            rd(4'h0, (statusWord0 & 16'h5fff) | 16'h2000);
            idle();
            @(negedge clk);
            chkWide(activeCfg[111:0], pk(good));
        end
        w = good;
        w[1] = 16'h4000;
        cfgw(w);
        rd(4'h1, 16'h4000);
        $display("test 4 done");
        foreach (fmts[k]) begin
            w = good;
            w[0] = 16'h8000 | {6'h0, fmts[k], 7'h0};
            cfgw(w);
            p = $signed(rnd()) % 32'sd32767999;
            e = enc2(p, fmts[k][1], fmts[k][0]);
            wr(4'h0, 16'h0000);
            wr(4'h2, e[31:16]);
            wr(4'h3, e[15:0]);
            wr(4'h1, e[15:0]);
            wr(4'ha, 16'h0000);
            idle();
            @(negedge clk);
            chkWide({80'h0, cmdParam[0]}, {80'h0, p});
            chkWord(cmdLevel1, e[15:0]);
            chkWord(cmdEdge1, e[15:0] & 16'h9ffe);
            readCmd(fmts[k][2], fmts[k][0]);
        end
        $display("test 5 done");
        w = good;
        w[0] = 16'h8400;
        cfgw(w);
        waitFlash();
        rd(4'h9, 16'haaaa);
        failNext <= 1'b1;
        cfgw(good);
        cfgw(w);
        waitFlash();
        rd(4'h9, 16'heeee);
        $display("test 6 done");
        wr(4'h0, 16'h0000);
        wr(4'ha, 16'h0000);
        w = good;
        w[0] = 16'h8800;
        w[4] = 16'h0300;
        cfgw(w);
        rd(4'h4, 16'h00c8);
        idle();
        @(negedge clk);
        chkWide(activeCfg[111:0], pk(good));
        $display("test 7 done");
        sense(2'b00, 16'h0003);
        w = good;
        w[0] = 16'h8003;
        cfgw(w);
        sense(2'b10, 16'h0002);
        sense(2'b00, 16'h0000);
        wr(4'hc, 16'hffff);
        rd(4'hb, 16'h0000);
        rd(4'h4, 16'h00c8);
        idle();
        $display("test 8 done");
        repeat (4) @(negedge clk);
        if (rdQ.size() != 0 || edgeQ.size() != 0)
            errTotal++;
        stopTest();
    end
endmodule
